// *** test_tof_sensor_i2c_target_port.sv ***
// self-checking bench joining host and target ends over the two-wire bus
`timescale 1ns/10ps
module test_tof_sensor_i2c_target_port import tsp_pkg::*; ;
  // ----------------------------------------------------------------
  // signals and instances
  // ----------------------------------------------------------------
  logic        clk;
  logic        nrst;
  logic        cmdValid;
  logic        cmdReady;
  logic        cmdLast;
  logic        rspValid;
  logic        rspReady;
  logic        rspNack;
  logic        lowPowerHoldPinN;
  logic        ifSelect;
  logic        busy;
  tsp_cmd_t    cmdOp;
  logic [15:0] cmdIndex;
  logic [7:0]  cmdData;
  logic [7:0]  rspData;
  logic [7:0]  lastWrite;
  logic [7:0]  ix;
  logic [7:0]  dv;
  logic [7:0]  mem [256];
  int          fail_count;
  int          cmp_count;
  int          seed;
  tsp_bus_if bus ();
  tsp_host u_tsp_host (.clk(clk), .nrst(nrst), .bus(bus.host), .cmdValid(cmdValid),
    .cmdReady(cmdReady), .cmdOp(cmdOp), .cmdIndex(cmdIndex), .cmdData(cmdData),
    .cmdLast(cmdLast), .rspValid(rspValid), .rspReady(rspReady), .rspData(rspData),
    .rspNack(rspNack));
  tsp_target u_tsp_target (.clk(clk), .nrst(nrst), .bus(bus.target),
    .lowPowerHoldPinN(lowPowerHoldPinN), .ifSelect(ifSelect), .busy(busy),
    .lastWrite(lastWrite));
  tsp_bus_sva u_tsp_bus_sva (.clk(clk), .nrst(nrst), .sclOe(bus.sclOe),
    .sdaHostOe(bus.sdaHostOe), .sdaTgtOe(bus.sdaTgtOe), .scl(bus.scl), .sda(bus.sda),
    .lowPowerHoldPinN(lowPowerHoldPinN));
  // ----------------------------------------------------------------
  // compare and bus tasks
  // ----------------------------------------------------------------
  task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk8
  task automatic chkBit(input string what, input logic exp, input logic got);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %b seen %b", what, exp, got);
    end
  endtask : chkBit
  task automatic end_of_test();
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : end_of_test
  // hold the request until the edge that takes it
  task automatic issue(input tsp_cmd_t op, input logic [7:0] idx, input logic [7:0] d);
    int n;
    n = 0;
    @(negedge clk);
    cmdValid = 1'b1;
    cmdOp    = op;
    cmdIndex = {8'h00, idx};
    cmdData  = d;
    do begin
      @(posedge clk);
      n++;
    end while (cmdReady !== 1'b1 && n < 5000);
    @(negedge clk);
    cmdValid = 1'b0;
  endtask : issue
  task automatic waitIdle();
    int n;
    n = 0;
    while (!(cmdReady === 1'b1 && busy === 1'b0) && n < 5000) begin
      @(negedge clk);
      n++;
    end
  endtask : waitIdle
  task automatic getRsp(input logic [7:0] exp);
    int n;
    n = 0;
    @(negedge clk);
    rspReady = 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (rspValid !== 1'b1 && n < 5000);
    chk8("rspData", exp, rspData);
    @(negedge clk);
    rspReady = 1'b0;
  endtask : getRsp
  // reads queue up behind a stalled answer buffer, then drain in order
  task automatic readBack(input logic [7:0] idx, input int cnt);
    issue(TSP_CMD_SETIX, idx, 8'h00);
    waitIdle();
    for (int k = 0; k < cnt; k++) begin
      issue(TSP_CMD_READ, 8'h00, 8'h00);
    end
    for (int k = 0; k < cnt; k++) begin
      getRsp(mem[idx + 8'(k)]);
    end
    waitIdle();
  endtask : readBack
  // ----------------------------------------------------------------
  // clock, watchdog and tests
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    #(40 * 90000);
    fail_count++;
    end_of_test();
  end
  initial begin
    {nrst, cmdValid, rspReady, ifSelect} = 4'h0;
    {cmdLast, lowPowerHoldPinN} = 2'b11;
    cmdOp = TSP_CMD_WRITE;
    {cmdIndex, cmdData} = 24'h000000;
    {fail_count, cmp_count} = 0;
    seed = 32'h1e9b1dc3;
    repeat (6) @(negedge clk);
    nrst = 1'b1;
    // corner indexes first, fe run wraps the index past ff
    for (int t = 0; t < 4; t++) begin
      ix = (t == 0) ? 8'hfe : (t == 1) ? 8'h00 : 8'($random(seed));
      for (int k = 0; k < 3; k++) begin
        dv = 8'($random(seed));
        issue(TSP_CMD_WRITE, ix + 8'(k), dv);
        waitIdle();
        mem[ix + 8'(k)] = dv;
        chk8("lastWrite", dv, lastWrite);
        chkBit("rspNack", 1'b0, rspNack);
      end
      readBack(ix, 3);
    end
    $display("test 1 done");
    lowPowerHoldPinN = 1'b0;
    repeat (8) @(negedge clk);
    issue(TSP_CMD_WRITE, ix, ~mem[ix]);
    waitIdle();
    chk8("lastWrite", dv, lastWrite);
    chkBit("rspNack", 1'b1, rspNack);
    lowPowerHoldPinN = 1'b1;
    repeat (8) @(negedge clk);
    readBack(ix, 1);
    $display("test 2 done");
    ifSelect = 1'b1;
    repeat (4) @(negedge clk);
    ifSelect = 1'b0;
    repeat (8) @(negedge clk);
    readBack(ix + 8'd1, 2);
    chkBit("busy", 1'b0, busy);
    $display("test 3 done");
    end_of_test();
  end
endmodule : test_tof_sensor_i2c_target_port

// *** tsp_bus_if.sv ***
// two-wire bus carrier joining host and target ends
`timescale 1ns/10ps
interface tsp_bus_if;
  logic sclOe;
  logic sdaHostOe;
  logic sdaTgtOe;
  logic scl;
  logic sda;
  // open drain wired-and with pull-ups: a driver only ever pulls low
  assign scl = ~sclOe;                    // see (RL1)
  assign sda = ~(sdaHostOe | sdaTgtOe);   // see (RL1)
  modport host (output sclOe, output sdaHostOe, input scl, input sda);
  modport target (output sdaTgtOe, input scl, input sda);
endinterface : tsp_bus_if

// *** tsp_bus_sva.sv ***
// protocol checker watching the two-wire bus between host and target ends
`timescale 1ns/10ps
module tsp_bus_sva import tsp_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // bus lines
  input wire logic sclOe,
  input wire logic sdaHostOe,
  input wire logic sdaTgtOe,
  input wire logic scl,
  input wire logic sda,
  // sensor pin
  input wire logic lowPowerHoldPinN
);
  // ----------------------------------------------------------------
  // bus event tracking
  // ----------------------------------------------------------------
  localparam int MIN_BIT = 25;  // cycles per bit at 1 Mbit/s
  logic       sclReg;
  logic       sdaReg;
  logic       dirReg;
  logic       seenReg;
  logic       freeReg;
  logic [3:0] bitReg;
  logic [1:0] byteReg;
  logic [7:0] shiftReg;
  logic [5:0] perReg;
  wire        rise    = scl & ~sclReg;
  wire        startEv = scl & sclReg & sdaReg & ~sda;
  wire        stopEv  = scl & sclReg & ~sdaReg & sda;
  wire        ackRise = rise & (bitReg == 4'd8);
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      {sclReg, sdaReg, freeReg, dirReg, seenReg} <= 5'h1c;
      {bitReg, byteReg, shiftReg} <= 14'h0000;
      perReg <= 6'h00;
    end else begin
      sclReg   <= scl;
      sdaReg   <= sda;
      freeReg  <= stopEv | (freeReg & ~startEv);
      seenReg  <= seenReg | rise;
      perReg   <= rise ? 6'h01 : perReg + 6'((perReg != 6'h3f));
      shiftReg <= rise ? {shiftReg[6:0], sda} : shiftReg;
      dirReg   <= (ackRise && byteReg == 2'd0) ? shiftReg[0] : dirReg;
      bitReg   <= startEv ? 4'd0 : rise ? ((bitReg == 4'd9) ? 4'd1 : bitReg + 4'd1) : bitReg;
      byteReg  <= startEv ? 2'd0 : byteReg + 2'((ackRise && byteReg != 2'd3));
    end
  end
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence ackSlot;
    ackRise;
  endsequence
  sequence dataSlot;
    rise && bitReg != 4'd8;
  endsequence
  a_open_drain: assert property (scl == !sclOe && sda == !(sdaHostOe || sdaTgtOe))
    else $error("bus level does not match pull-down enables");
  a_idle_released: assert property (freeReg |-> !sdaTgtOe && !sclOe)
    else $error("line held low while bus free");
  a_bit_rate: assert property (rise && seenReg |-> perReg >= MIN_BIT)
    else $error("scl faster than allowed bit rate");
  wire ownAddr = byteReg == 2'd0 && shiftReg[7:1] == TSP_DEV_ADDR && lowPowerHoldPinN;
  wire wrByte  = byteReg != 2'd0 && !dirReg && lowPowerHoldPinN;
  a_addr_ack: assert property (ackSlot ##0 ownAddr |-> sdaTgtOe && !sda)
    else $error("own address not acknowledged");
  a_write_ack: assert property (ackSlot ##0 wrByte |-> sdaTgtOe)
    else $error("written byte not acknowledged");
  a_read_ack_free: assert property (ackSlot ##0 (byteReg != 2'd0 && dirReg) |-> !sdaTgtOe)
    else $error("target holds sda in host acknowledge slot");
  a_write_tgt_off: assert property (dataSlot ##0 (byteReg == 2'd0 || !dirReg) |-> !sdaTgtOe)
    else $error("target drives sda in a host data bit");
  a_tgt_stable_high: assert property (scl && sclReg |-> $stable(sdaTgtOe))
    else $error("target changed sda while scl high");
  // the stop's own scl pulse is the one rise after the acknowledge
  a_whole_bytes: assert property (stopEv |-> bitReg == 4'd1)
    else $error("stop inside a byte");
  // the pin filter and the kill take some cycles before sda lets go
  a_disabled_quiet: assert property (!lowPowerHoldPinN [*8] |-> !sdaTgtOe)
    else $error("disabled port drives sda");
endmodule : tsp_bus_sva

// *** tsp_host.sv ***
// host bus controller end: makes scl, writes and reads target registers
`timescale 1ns/10ps
module tsp_host import tsp_pkg::*; #(
  parameter int HALF_CYC = TSP_HALF_CYC
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       nrst,
  // bus
  tsp_bus_if.host         bus,
  // command side
  input  wire logic       cmdValid,
  output logic            cmdReady,
  input  wire tsp_cmd_t   cmdOp,
  input  wire logic [15:0] cmdIndex,
  input  wire logic [7:0] cmdData,
  input  wire logic       cmdLast,
  // answer side, two-entry buffer
  output logic            rspValid,
  input  wire logic       rspReady,
  output logic [7:0]      rspData,
  output logic            rspNack
);
  initial begin
    if (HALF_CYC < TSP_HALF_CYC || HALF_CYC > 65536) $error("HALF_CYC out of range");
  end
  // ----------------------------------------------------------------
  // bit engine: each phase lasts HALF_CYC clocks, except while stall holds the count at zero
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    H_IDLE = 3'b000, H_START = 3'b001, H_BIT = 3'b011, H_STOP = 3'b010, H_RSTART = 3'b110
  } tsp_hstate_t;
  tsp_hstate_t st_reg;
  logic [15:0] cnt_reg;
  logic [1:0]  ph_reg;
  logic [3:0]  bit_reg;
  logic [8:0]  tx_reg;
  logic [7:0]  rx_reg;
  logic [2:0]  seq_reg;  // 0 addr,1 idxh,2 idxl,3 data
  logic        rd_reg, last_reg, sclOe_reg, sdaOe_reg, nack_reg;
  logic [15:0] idx_reg;
  logic [7:0]  dat_reg;
  logic [7:0]  bufData [2];
  logic        wp_reg, rp_reg, ixOnly_reg, sdaF_reg;
  logic [2:0]  sdaSync_reg;
  logic [1:0]  fill_reg;
  wire tick    = (cnt_reg == 16'(HALF_CYC - 1));  // see (RL4)
  wire bufFull = (fill_reg == 2'h2);
  wire push    = (st_reg == H_BIT) && tick && ph_reg == 2'h1 && bit_reg == 4'h8
                 && rd_reg && seq_reg == 3'h3;
  wire pop     = rspValid && rspReady;
  wire doPush  = push && !bufFull;
  wire rpNext  = pop ? ~rp_reg : rp_reg;
  wire [1:0] fillNext = fill_reg + 2'(doPush) - 2'(pop);
  // a byte pushed into an emptied buffer is the head at once, before the array has it
  wire [7:0] headData = (doPush && fill_reg == 2'(pop)) ? rx_reg : bufData[rpNext];
  // stall the clock while the buffer cannot take a read byte
  wire stall   = rd_reg && seq_reg == 3'h3 && bufFull && bit_reg == 4'h8;
  assign cmdReady = (st_reg == H_IDLE) && !sclOe_reg;
  // sda comes from the far end: three flops, change taken when the last two agree
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sdaSync_reg <= 3'h7;
      sdaF_reg    <= 1'b1;
    end else begin
      sdaSync_reg <= {sdaSync_reg[1:0], bus.sda};
      if (sdaSync_reg[1] == sdaSync_reg[2]) sdaF_reg <= sdaSync_reg[2];
    end
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) cnt_reg <= 16'h0000;
    else if (tick || st_reg == H_IDLE || stall) cnt_reg <= 16'h0000;
    else cnt_reg <= cnt_reg + 16'h0001;
  end
  // byte to send (address, index or data) with a released ack bit in the lsb
  function automatic logic [8:0] frame(input logic [7:0] b);
    frame = {b, 1'b1};
  endfunction : frame
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_reg <= H_IDLE; ph_reg <= 2'h0; bit_reg <= 4'h0; tx_reg <= 9'h1ff;
      rx_reg <= 8'h00; seq_reg <= 3'h0; rd_reg <= 1'b0; last_reg <= 1'b0;
      sclOe_reg <= 1'b0; sdaOe_reg <= 1'b0; nack_reg <= 1'b0;
      idx_reg <= 16'h0000; dat_reg <= 8'h00;
      ixOnly_reg <= 1'b0;
    end else begin
      unique case (st_reg)
        H_IDLE: begin
          sclOe_reg <= 1'b0;  // see (RL2)
          sdaOe_reg <= 1'b0;
          if (cmdValid && cmdReady) begin
            rd_reg   <= (cmdOp == TSP_CMD_READ);
            ixOnly_reg <= (cmdOp == TSP_CMD_SETIX);
            last_reg <= cmdLast;
            idx_reg  <= cmdIndex;
            dat_reg  <= cmdData;
            // reads from the current index skip the index phase
            tx_reg   <= frame((cmdOp == TSP_CMD_READ) ? TSP_ADDR_RD : TSP_ADDR_WR);  // see (RL10)
            seq_reg  <= 3'h0;
            st_reg   <= H_START;  // see (RL11)
          end
        end
        H_START, H_RSTART: if (tick) begin
          // sda falls while scl is high, then scl falls
          if (!sdaOe_reg) sdaOe_reg <= 1'b1;  // see (RL8)
          else begin
            sclOe_reg <= 1'b1;  // see (RL3)
            st_reg <= H_BIT; bit_reg <= 4'h0; ph_reg <= 2'h0;
          end
        end
        H_BIT: if (tick) begin
          if (ph_reg == 2'h0) begin
            // scl low: present the bit, ack slot always released, so a read byte is nacked
            sdaOe_reg <= ~tx_reg[8];  // see (RL7)
            sclOe_reg <= 1'b0;
            ph_reg    <= 2'h1;
          end else begin
            if (bit_reg < 4'h8) rx_reg <= {rx_reg[6:0], sdaF_reg};
            else nack_reg <= sdaF_reg;  // see (RL17)
            sclOe_reg <= 1'b1;
            tx_reg    <= {tx_reg[7:0], 1'b1};
            ph_reg    <= 2'h0;
            if (bit_reg != 4'h8) bit_reg <= bit_reg + 4'h1;  // see (RL6)
            else begin
              bit_reg <= 4'h0;
              if (sdaF_reg && !(rd_reg && seq_reg == 3'h3)) st_reg <= H_STOP;
              else if (rd_reg) begin
                seq_reg <= 3'h3;
                // host nack ends a read after its one byte
                tx_reg  <= 9'h1ff;  // see (RL18)
                if (seq_reg == 3'h3) st_reg <= H_STOP;
              end else if (seq_reg == 3'h3 || (ixOnly_reg && seq_reg == 3'h2)) begin
                // index-only command stops once the index is in
                st_reg <= H_STOP;  // see (RL20)
              end else begin
                seq_reg <= seq_reg + 3'h1;
                tx_reg  <= frame((seq_reg == 3'h0) ? idx_reg[15:8]
                           : (seq_reg == 3'h1) ? idx_reg[7:0] : dat_reg);  // see (RL14)
              end
            end
          end
        end
        H_STOP: if (tick) begin
          // sda held low, scl released, then sda rises
          if (sclOe_reg) begin sdaOe_reg <= 1'b1; sclOe_reg <= 1'b0; end
          else begin sdaOe_reg <= 1'b0; st_reg <= H_IDLE; end  // see (RL9)
        end
        default: st_reg <= H_IDLE;
      endcase
    end
  end
  // ----------------------------------------------------------------
  // two-entry answer buffer
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wp_reg <= 1'b0; rp_reg <= 1'b0; fill_reg <= 2'h0;
      rspValid <= 1'b0; rspData <= 8'h00; rspNack <= 1'b0;
    end else begin
      if (doPush) begin
        bufData[wp_reg] <= rx_reg;
        wp_reg <= ~wp_reg;
      end
      rp_reg   <= rpNext;
      fill_reg <= fillNext;
      rspValid <= fillNext != 2'h0;
      rspData  <= headData;
      rspNack  <= nack_reg;
    end
  end
  assign bus.sclOe     = sclOe_reg;  // see (RL1)
  assign bus.sdaHostOe = sdaOe_reg;
endmodule : tsp_host

// *** tsp_pkg.sv ***
// shared constants for the ranging sensor i2c target port and its host end
// Functional notes
// (RL1) lines only pulled low, released means high
// (RL2) idle bus: both lines released high
// (RL3) host makes every clock pulse, starts transfers
// (RL4) bus rate up to 1 Mbit/s
// (RL5) target answers address byte 0x52
// (RL6) eight bits then one acknowledge slot
// (RL7) sample on scl rise, hold while high
// (RL8) detect start and stop while scl high
// (RL9) message ends by stop or repeated start
// (RL10) address lsb selects write or read
// (RL11) host always opens with a start
// (RL12) target acknowledges its valid address
// (RL13) direction bit latched for whole message
// (RL14) write carries 16-bit index before data
// (RL15) shift, acknowledge, then store data byte
// (RL16) read loads register, shifts out on scl fall
// (RL17) receiver acknowledges every byte
// (RL18) only host ends message, stop or nack
// (RL19) index advances by one per further byte
// (RL20) host may stream writes without new index
// (RL21) low-power hold disables port, keeps registers
// (RL22) select pin pulse resets only port logic
// (RL23) foreign address: release sda until start
package tsp_pkg;
  // ----------------------------------------------------------------
  // bus constants
  // ----------------------------------------------------------------
  localparam logic [6:0] TSP_DEV_ADDR  = 7'h29;  // byte 0x52 with rw in lsb
  localparam logic [7:0] TSP_ADDR_WR   = 8'h52;
  localparam logic [7:0] TSP_ADDR_RD   = 8'h53;
  localparam int         TSP_BYTE_BITS = 8;
  localparam int         TSP_IDX_W     = 16;
  localparam int         TSP_CLK_MHZ   = 25;
  localparam int         TSP_MAX_KBPS  = 1000;
  // half bit period in cycles, rounded up so the rate never exceeds the maximum
  localparam int         TSP_HALF_CYC  = (TSP_CLK_MHZ * 1000 + 2 * TSP_MAX_KBPS - 1)
                                         / (2 * TSP_MAX_KBPS);
  // ----------------------------------------------------------------
  // target states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    TSP_T_IDLE = 3'b000,
    TSP_T_ADDR = 3'b001,
    TSP_T_IDXH = 3'b011,
    TSP_T_IDXL = 3'b010,
    TSP_T_WDAT = 3'b110,
    TSP_T_RDAT = 3'b111,
    TSP_T_IGN  = 3'b101
  } tsp_tstate_t;
  // host commands
  typedef enum logic [1:0] {
    TSP_CMD_WRITE = 2'b00,
    TSP_CMD_READ  = 2'b01,
    TSP_CMD_SETIX = 2'b10
  } tsp_cmd_t;
endpackage : tsp_pkg

// *** tsp_target.sv ***
// i2c target end of the ranging sensor port, with its register store
`timescale 1ns/10ps
module tsp_target import tsp_pkg::*; #(
  parameter int REG_DEPTH = 256
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       nrst,
  // bus
  tsp_bus_if.target       bus,
  // sensor control pins
  input  wire logic       lowPowerHoldPinN,
  input  wire logic       ifSelect,
  // status
  output logic            busy,
  output logic [7:0]      lastWrite
);
  initial begin
    // the index is cut to AW bits, so only a power of two fills the store exactly
    if (REG_DEPTH < 2 || REG_DEPTH > 65536 || (REG_DEPTH & (REG_DEPTH - 1)) != 0) begin
      $error("REG_DEPTH out of range");
    end
  end
  localparam int AW = $clog2(REG_DEPTH);
  // ----------------------------------------------------------------
  // input sampling, three stages, change accepted when last two agree
  // ----------------------------------------------------------------
  logic [2:0] sclSync_reg, sdaSync_reg, lpSync_reg, selSync_reg;
  logic       sclF_reg, sdaF_reg, lpF_reg, selF_reg;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sclSync_reg <= 3'h7;
      sdaSync_reg <= 3'h7;
      lpSync_reg  <= 3'h7;
      selSync_reg <= 3'h0;
    end else begin
      sclSync_reg <= {sclSync_reg[1:0], bus.scl};
      sdaSync_reg <= {sdaSync_reg[1:0], bus.sda};
      lpSync_reg  <= {lpSync_reg[1:0], lowPowerHoldPinN};
      selSync_reg <= {selSync_reg[1:0], ifSelect};
    end
  end
  wire sclAgree = sclSync_reg[1] == sclSync_reg[2];
  wire sdaAgree = sdaSync_reg[1] == sdaSync_reg[2];
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sclF_reg <= 1'b1;
      sdaF_reg <= 1'b1;
      lpF_reg  <= 1'b1;
      selF_reg <= 1'b0;
    end else begin
      if (sclAgree) sclF_reg <= sclSync_reg[2];
      if (sdaAgree) sdaF_reg <= sdaSync_reg[2];
      if (lpSync_reg[1] == lpSync_reg[2]) lpF_reg <= lpSync_reg[2];
      if (selSync_reg[1] == selSync_reg[2]) selF_reg <= selSync_reg[2];
    end
  end
  wire sclNew   = sclAgree ? sclSync_reg[2] : sclF_reg;
  wire sdaNew   = sdaAgree ? sdaSync_reg[2] : sdaF_reg;
  wire sclRise  = sclNew & ~sclF_reg;
  wire sclFall  = ~sclNew & sclF_reg;
  wire startEv  = sclF_reg & sclNew & sdaF_reg & ~sdaNew;  // see (RL8)
  wire stopEv   = sclF_reg & sclNew & ~sdaF_reg & sdaNew;  // see (RL8)
  // select pin back to 0 after a 1 clears the port only
  wire selReset = selF_reg & ~selSync_reg[2] & ~selSync_reg[1];  // see (RL22)
  wire portOff  = ~lpF_reg;  // see (RL21)
  wire portKill = selReset | portOff;
  // ----------------------------------------------------------------
  // register store, kept through low-power hold
  // ----------------------------------------------------------------
  logic [7:0] regMem [REG_DEPTH];  // see (RL21)
  // ----------------------------------------------------------------
  // protocol engine
  // ----------------------------------------------------------------
  tsp_tstate_t           state_reg;
  logic [7:0]            shift_reg;
  logic [3:0]            bitCnt_reg;
  logic                  ackSlot_reg, sdaOe_reg, rdNack_reg, rnw_reg;
  logic [TSP_IDX_W-1:0]  index_reg;
  logic [7:0]            last_reg;
  wire  [AW-1:0]         memIdx  = index_reg[AW-1:0];
  wire                   byteEnd = (bitCnt_reg == 4'(TSP_BYTE_BITS));
  wire  [7:0]            rxByte  = {shift_reg[6:0], sdaNew};
  // the index one on, used to preload the next read byte
  wire  [AW-1:0]         nextIdx = AW'(index_reg + 16'h0001);
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_reg   <= TSP_T_IDLE;
      shift_reg   <= 8'h00;
      bitCnt_reg  <= 4'h0;
      ackSlot_reg <= 1'b0;
      sdaOe_reg   <= 1'b0;
      rdNack_reg  <= 1'b0;
      rnw_reg     <= 1'b0;
      index_reg   <= '0;
      last_reg    <= 8'h00;
    end else if (portKill) begin
      state_reg   <= TSP_T_IDLE;  // see (RL2)
      sdaOe_reg   <= 1'b0;
      bitCnt_reg  <= 4'h0;
      ackSlot_reg <= 1'b0;
    end else if (startEv) begin
      state_reg   <= TSP_T_ADDR;  // see (RL9)
      bitCnt_reg  <= 4'h0;
      ackSlot_reg <= 1'b0;
      sdaOe_reg   <= 1'b0;
    end else if (stopEv) begin
      state_reg   <= TSP_T_IDLE;  // see (RL9)
      sdaOe_reg   <= 1'b0;
    end else if (state_reg != TSP_T_IDLE && state_reg != TSP_T_IGN) begin
      if (sclRise && !ackSlot_reg) begin
        shift_reg  <= rxByte;  // see (RL7)
        bitCnt_reg <= bitCnt_reg + 4'h1;
      end else if (sclRise && ackSlot_reg && state_reg == TSP_T_RDAT) begin
        rdNack_reg <= sdaNew;  // see (RL17)
      end else if (sclFall && !ackSlot_reg && byteEnd) begin
        // eighth bit done: decide the acknowledge slot
        ackSlot_reg <= 1'b1;  // see (RL6)
        bitCnt_reg  <= 4'h0;
        unique case (state_reg)
          TSP_T_ADDR: begin
            if (shift_reg[7:1] == TSP_DEV_ADDR) begin  // see (RL5)
              rnw_reg   <= shift_reg[0];  // see (RL10)
              sdaOe_reg <= 1'b1;  // see (RL12)
            end else begin
              state_reg <= TSP_T_IGN;  // see (RL23)
              sdaOe_reg <= 1'b0;
            end
          end
          TSP_T_IDXH: begin
            index_reg[15:8] <= shift_reg;  // see (RL14)
            sdaOe_reg <= 1'b1;
          end
          TSP_T_IDXL: begin
            index_reg[7:0] <= shift_reg;
            sdaOe_reg <= 1'b1;
          end
          TSP_T_WDAT: begin
            sdaOe_reg <= 1'b1;  // see (RL15)
          end
          default: begin
            sdaOe_reg <= 1'b0;  // read byte: host answers
          end
        endcase
      end else if (sclFall && ackSlot_reg) begin
        ackSlot_reg <= 1'b0;
        sdaOe_reg   <= 1'b0;
        unique case (state_reg)
          TSP_T_ADDR: begin
            // direction latched here steers the rest of the message
            if (rnw_reg) begin  // see (RL13)
              state_reg <= TSP_T_RDAT;
              shift_reg <= regMem[memIdx];  // see (RL16)
              sdaOe_reg <= ~regMem[memIdx][7];
            end else begin
              state_reg <= TSP_T_IDXH;
            end
          end
          TSP_T_IDXH: state_reg <= TSP_T_IDXL;
          TSP_T_IDXL: state_reg <= TSP_T_WDAT;
          TSP_T_WDAT: begin
            index_reg <= index_reg + 16'h0001;  // see (RL19)
            last_reg  <= shift_reg;
          end
          default: begin
            // every byte read moves the index on, so a later read continues from there
            index_reg <= index_reg + 16'h0001;  // see (RL19)
            if (rdNack_reg) begin
              state_reg <= TSP_T_IGN;  // see (RL18)
            end else begin
              shift_reg <= regMem[nextIdx];
              sdaOe_reg <= ~regMem[nextIdx][7];
            end
          end
        endcase
      end else if (sclFall && state_reg == TSP_T_RDAT) begin
        // next bit out on the falling edge; only ever pulls low
        // the rise already shifted, so the top bit is the next one due
        sdaOe_reg <= ~shift_reg[7];  // see (RL16)
      end
    end
  end
  // store after the acknowledge so a nacked-by-stop byte is still kept
  wire storeEn = ~portKill & ~startEv & ~stopEv & sclFall & ackSlot_reg
                 & (state_reg == TSP_T_WDAT);
  always_ff @(posedge clk) begin
    if (storeEn) regMem[memIdx] <= shift_reg;  // see (RL15)
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      busy      <= 1'b0;
      lastWrite <= 8'h00;
    end else begin
      busy      <= (state_reg != TSP_T_IDLE) && (state_reg != TSP_T_IGN);
      lastWrite <= last_reg;
    end
  end
  assign bus.sdaTgtOe = sdaOe_reg;  // see (RL1)
endmodule : tsp_target
